// [hw/pmf_pkg.sv]
// Constants for the power monitor flag logic: map, fields, reset values
//
// What this block does
// - Power-on reset sets power-on flag
// - Other resets leave power-on flag alone
// - Hold system reset while any supply low
// - Low-voltage reset flag set in full mode
// - No low-voltage reset in reduced mode
// - Main supply low sets warning, gated interrupt
// - Writing main acknowledge one clears warning
// - Reference supply low sets warning, gated interrupt
// - Writing reference acknowledge one clears warning
// - Two-bit reference warning threshold forwarded
// - Warnings disabled in reduced mode
// - Precision reference ready flag; off in reduced
// - Sensor on only when enabled, not reduced
// - Select bit picks sensor or bandgap voltage
// - High temperature status follows hysteresis comparator
// - Status change sets flag when enabled
// - Writing one clears high temperature flag
// - Trim enable applies four-bit threshold trim
// - Trim registers need global write enable
// - Oscillator on in full, stoppable in reduced
// - Six-bit oscillator trim driven, write protected
// - Reference supply ready after enable
`default_nettype none
package pmf_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;    // Control
  localparam logic [7:0] OFS_RST = 8'h04;     // Reset flags
  localparam logic [7:0] OFS_LVW1 = 8'h08;    // Main supply warning
  localparam logic [7:0] OFS_LVW2 = 8'h0c;    // Reference supply warning
  localparam logic [7:0] OFS_REFLVW = 8'h10;  // Reference warning level
  localparam logic [7:0] OFS_STAT = 8'h14;    // Ready status
  localparam logic [7:0] OFS_TPCTRL = 8'h18;  // Temperature control
  localparam logic [7:0] OFS_TPTM = 8'h1c;    // Temperature trim
  localparam logic [7:0] OFS_OSCTRM = 8'h20;  // Oscillator trim
  localparam logic [7:0] OFS_REFCFG = 8'h24;  // Reference config

  ////////////////////////////////////////////////////////////////////////////
  // Field positions
  localparam int B_GWE = 0;       // Control: global write enable
  localparam int B_REFDN = 1;     // Control: reference regulator off
  localparam int B_OSCSTP = 2;    // Control: oscillator runs in reduced
  localparam int B_PWRON = 0;     // Reset: power-on flag
  localparam int B_LOWRST = 1;    // Reset: low-voltage reset flag
  localparam int B_WFLAG = 0;     // Warning: flag
  localparam int B_WIE = 1;       // Warning: interrupt enable
  localparam int B_WACK = 2;      // Warning: acknowledge
  localparam int B_SUPRDY = 0;    // Status: reference supply ready
  localparam int B_PRERDY = 2;    // Status: precision reference ready
  localparam int B_TEN = 0;       // Temp: sensor enable
  localparam int B_TSEL = 1;      // Temp: output select
  localparam int B_HTS = 2;       // Temp: high temperature status
  localparam int B_HTEN = 3;      // Temp: interrupt enable
  localparam int B_HTFLAG = 4;    // Temp: interrupt flag
  localparam int B_TRMEN = 7;     // Trim: trim enable

  ////////////////////////////////////////////////////////////////////////////
  // Synchronised analog inputs, index in the input vector
  localparam int NSYNC = 10;      // Number of monitored lines
  localparam int S_SUPLOW = 0;    // First of three supply-low lines
  localparam int S_WMAIN = 3;     // Main supply warning level
  localparam int S_WREF = 4;      // Reference supply warning level
  localparam int S_PRERDY = 5;    // Precision reference ready
  localparam int S_SUPRDY = 6;    // Reference regulator ready
  localparam int S_HTCMP = 7;     // High temperature comparator
  localparam int S_REDUCED = 8;   // Reduced performance mode
  localparam int S_SRST = 9;      // Other system reset request

  ////////////////////////////////////////////////////////////////////////////
  // Reset values
  localparam logic [5:0] RST_OSCTRIM = 6'h20;  // Oscillator trim
  localparam logic [5:0] RST_REFTRIM = 6'h20;  // Reference trim
  localparam logic [3:0] RST_TTRIM = 4'h8;     // Temperature trim
  localparam logic [1:0] RST_REFTHR = 2'h0;    // Reference level select

  // Set wins over clear for every hardware flag
  function automatic logic flag_next(input logic q, input logic set,
                                     input logic clr);
    flag_next = set | (q & ~clr);
  endfunction

endpackage
`default_nettype wire

// [hw/pmf_sync.sv]
// Three-stage synchroniser with agreement filter for analog inputs
`timescale 1ns/100ps
`default_nettype none
module pmf_sync
  import pmf_pkg::*;
(
  input wire logic i_mclk,               // System clock
  input wire logic i_rst_n,              // Async reset, active low
  input wire logic [NSYNC-1:0] i_async,  // Raw lines
  output logic [NSYNC-1:0] o_sync        // Filtered lines
);

  logic [NSYNC-1:0] s1_q; // First stage, read by second only
  logic [NSYNC-1:0] s2_q; // Second stage
  logic [NSYNC-1:0] s3_q; // Third stage
  logic [NSYNC-1:0] out_q; // Accepted value

  ////////////////////////////////////////////////////////////////////////////
  // Shift chain
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end else begin
      s1_q <= i_async;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // A change counts once stages two and three agree
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      out_q <= '0;
    end else begin
      for (int i = 0; i < NSYNC; i++) begin
        if (s2_q[i] == s3_q[i]) begin
          out_q[i] <= s3_q[i];
        end
      end
    end
  end

  assign o_sync = out_q;

endmodule
`default_nettype wire

// [hw/pmf_top.sv]
// Power monitor flag, enable and write-protect logic with APB registers
//
// The placing of the registers and the APB slave port were decided locally.
`timescale 1ns/100ps
`default_nettype none
module pmf_top
  import pmf_pkg::*;
(
  input wire logic i_mclk,              // 20 MHz system clock
  input wire logic i_rst_n,             // Power-on reset, active low
  input wire logic i_psel,              // APB select
  input wire logic i_penable,           // APB enable
  input wire logic i_pwrite,            // APB direction
  input wire logic [7:0] i_paddr,       // APB byte address
  input wire logic [31:0] i_pwdata,     // APB write data
  output logic [31:0] o_prdata,         // APB read data
  output logic o_pready,                // APB ready
  output logic o_pslverr,               // APB error, unmapped
  input wire logic [2:0] i_supply_low,  // Supply below reset level
  input wire logic i_main_warn,         // Main supply below warning
  input wire logic i_ref_warn,          // Reference below warning
  input wire logic i_prec_ref_rdy,      // Precision reference ready
  input wire logic i_ref_sup_rdy,       // Reference regulator ready
  input wire logic i_ht_cmp,            // Hysteresis comparator out
  input wire logic i_reduced_mode,      // Reduced performance mode
  input wire logic i_sys_rst_req,       // Other system reset source
  output logic o_sys_rst_hold,          // Hold system in reset
  output logic o_main_warn_irq,         // Main warning interrupt
  output logic o_ref_warn_irq,          // Reference warning interrupt
  output logic o_ht_irq,                // High temperature interrupt
  output logic [1:0] o_ref_thr_sel,     // Reference warning level
  output logic o_warn_det_en,           // Warning detectors enable
  output logic o_prec_ref_en,           // Precision reference enable
  output logic o_ref_reg_en,            // Reference regulator enable
  output logic [5:0] o_ref_trim,        // Reference voltage trim
  output logic o_temp_en,               // Temperature sensor enable
  output logic o_temp_sel,              // 0 sensor, 1 bandgap
  output logic o_ht_trim_en,            // Use threshold trim
  output logic [3:0] o_ht_trim,         // Threshold trim
  output logic o_osc_en,                // Low-power oscillator run
  output logic [5:0] o_osc_trim         // Oscillator frequency trim
);

  ////////////////////////////////////////////////////////////////////////////
  // Synchronised inputs
  logic [NSYNC-1:0] raw; // Raw analog lines
  logic [NSYNC-1:0] s; // Filtered lines
  logic reduced; // Reduced performance mode
  logic soft_rst; // Other system reset

  assign raw = {i_sys_rst_req, i_reduced_mode, i_ht_cmp, i_ref_sup_rdy,
                i_prec_ref_rdy, i_ref_warn, i_main_warn, i_supply_low};

  pmf_sync i_pmf_sync (
    .i_mclk(i_mclk),
    .i_rst_n(i_rst_n),
    .i_async(raw),
    .o_sync(s)
  );

  assign reduced = s[S_REDUCED];
  assign soft_rst = s[S_SRST];

  ////////////////////////////////////////////////////////////////////////////
  // APB access decode
  logic wr; // Write takes effect now
  logic [31:0] wd; // Write data
  logic mapped; // Address hits a register

  assign wr = i_psel & i_penable & o_pready & i_pwrite;
  assign wd = i_pwdata;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
    hit = (a == o);
  endfunction

  assign mapped = hit(i_paddr, OFS_CTRL) | hit(i_paddr, OFS_RST) |
                  hit(i_paddr, OFS_LVW1) | hit(i_paddr, OFS_LVW2) |
                  hit(i_paddr, OFS_REFLVW) | hit(i_paddr, OFS_STAT) |
                  hit(i_paddr, OFS_TPCTRL) | hit(i_paddr, OFS_TPTM) |
                  hit(i_paddr, OFS_OSCTRM) | hit(i_paddr, OFS_REFCFG);

  ////////////////////////////////////////////////////////////////////////////
  // Register state
  logic gwe_q; // Global write enable
  logic refdn_q; // Reference regulator off
  logic oscstp_q; // Oscillator allowed to run in reduced mode
  logic pwr_on_flag_q; // Power-on reset flag
  logic low_rst_flag_q; // Low-voltage reset flag
  logic wmain_q; // Main supply warning flag
  logic wmain_ie_q; // Main supply warning interrupt enable
  logic wref_q; // Reference warning flag
  logic wref_ie_q; // Reference warning interrupt enable
  logic [1:0] refthr_q; // Reference warning level
  logic ten_q; // Sensor enable bit
  logic tsel_q; // Sensor output select
  logic hts_q; // High temperature status
  logic ht_ie_q; // High temperature interrupt enable
  logic ht_flag_q; // High temperature interrupt flag
  logic trmen_q; // Trim enable
  logic [3:0] ttrim_q; // Threshold trim
  logic [5:0] osctrim_q; // Oscillator trim
  logic [5:0] reftrim_q; // Reference trim
  logic low_rst_act; // Supply-low reset active now
  logic low_rst_act_q; // Previous supply-low state

  assign low_rst_act = (|s[S_SUPLOW+:3]) & ~reduced;

  ////////////////////////////////////////////////////////////////////////////
  // Control register; other system resets return it to defaults
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      gwe_q <= 1'b0;
      refdn_q <= 1'b0;
      oscstp_q <= 1'b1;
    end else if (soft_rst) begin
      gwe_q <= 1'b0;
      refdn_q <= 1'b0;
      oscstp_q <= 1'b1;
    end else if (wr && hit(i_paddr, OFS_CTRL)) begin
      gwe_q <= wd[B_GWE];
      refdn_q <= wd[B_REFDN];
      oscstp_q <= wd[B_OSCSTP];
    end
  end

  // Reset flags survive every reset except power-on
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pwr_on_flag_q <= 1'b1;
      low_rst_flag_q <= 1'b1;
      low_rst_act_q <= 1'b0;
    end else begin
      low_rst_act_q <= low_rst_act;
      pwr_on_flag_q <= flag_next(pwr_on_flag_q, 1'b0,
        wr && hit(i_paddr, OFS_RST) && wd[B_PWRON]);
      low_rst_flag_q <= flag_next(low_rst_flag_q,
        low_rst_act & ~low_rst_act_q,
        wr && hit(i_paddr, OFS_RST) && wd[B_LOWRST]);
    end
  end

  // Warning flags, detectors idle in reduced mode
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wmain_q <= 1'b0;
      wref_q <= 1'b0;
    end else begin
      wmain_q <= flag_next(wmain_q, s[S_WMAIN] & ~reduced,
                           wr && hit(i_paddr, OFS_LVW1) && wd[B_WACK]);
      wref_q <= flag_next(wref_q, s[S_WREF] & ~reduced,
                          wr && hit(i_paddr, OFS_LVW2) && wd[B_WACK]);
    end
  end

  // Warning enables and reference level select
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wmain_ie_q <= 1'b0;
      wref_ie_q <= 1'b0;
      refthr_q <= RST_REFTHR;
    end else if (soft_rst) begin
      wmain_ie_q <= 1'b0;
      wref_ie_q <= 1'b0;
      refthr_q <= RST_REFTHR;
    end else begin
      if (wr && hit(i_paddr, OFS_LVW1)) begin
        wmain_ie_q <= wd[B_WIE];
      end
      if (wr && hit(i_paddr, OFS_LVW2)) begin
        wref_ie_q <= wd[B_WIE];
      end
      if (wr && hit(i_paddr, OFS_REFLVW)) begin
        refthr_q <= wd[1:0];
      end
    end
  end

  // Temperature control bits
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ten_q <= 1'b0;
      tsel_q <= 1'b0;
      ht_ie_q <= 1'b0;
    end else if (soft_rst) begin
      ten_q <= 1'b0;
      tsel_q <= 1'b0;
      ht_ie_q <= 1'b0;
    end else if (wr && hit(i_paddr, OFS_TPCTRL)) begin
      ten_q <= wd[B_TEN];
      tsel_q <= wd[B_TSEL];
      ht_ie_q <= wd[B_HTEN];
    end
  end

  // Status tracks the comparator; any change flags when enabled
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      hts_q <= 1'b0;
      ht_flag_q <= 1'b0;
    end else begin
      hts_q <= s[S_HTCMP];
      ht_flag_q <= flag_next(ht_flag_q,
        ht_ie_q & (s[S_HTCMP] != hts_q),
        wr && hit(i_paddr, OFS_TPCTRL) && wd[B_HTFLAG]);
    end
  end

  // Protected trim registers, writes dropped without global enable
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      trmen_q <= 1'b0;
      ttrim_q <= RST_TTRIM;
      osctrim_q <= RST_OSCTRIM;
      reftrim_q <= RST_REFTRIM;
    end else if (wr && gwe_q) begin
      if (hit(i_paddr, OFS_TPTM)) begin
        trmen_q <= wd[B_TRMEN];
        ttrim_q <= wd[3:0];
      end
      if (hit(i_paddr, OFS_OSCTRM)) begin
        osctrim_q <= wd[5:0];
      end
      if (hit(i_paddr, OFS_REFCFG)) begin
        reftrim_q <= wd[5:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB slave: ready in the first cycle of the access phase, no wait states
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_pready <= 1'b0;
      o_pslverr <= 1'b0;
      o_prdata <= 32'h0;
    end else begin
      o_pready <= i_psel & ~i_penable;
      o_pslverr <= i_psel & ~i_penable & ~mapped;
      o_prdata <= 32'h0;
      if (i_psel && !i_penable && !i_pwrite) begin
        unique case (1'b1)
          hit(i_paddr, OFS_CTRL): o_prdata <= {29'h0, oscstp_q, refdn_q, gwe_q};
          hit(i_paddr, OFS_RST): o_prdata <= {30'h0, low_rst_flag_q,
            pwr_on_flag_q};
          hit(i_paddr, OFS_LVW1): o_prdata <= {30'h0, wmain_ie_q, wmain_q};
          hit(i_paddr, OFS_LVW2): o_prdata <= {30'h0, wref_ie_q, wref_q};
          hit(i_paddr, OFS_REFLVW): o_prdata <= {30'h0, refthr_q};
          hit(i_paddr, OFS_STAT): o_prdata <= {29'h0, o_prec_ref_en &
            s[S_PRERDY], 1'b0, o_ref_reg_en & s[S_SUPRDY]};
          hit(i_paddr, OFS_TPCTRL): o_prdata <= {27'h0, ht_flag_q, ht_ie_q,
            hts_q, tsel_q, ten_q};
          hit(i_paddr, OFS_TPTM): o_prdata <= {24'h0, trmen_q, 3'h0, ttrim_q};
          hit(i_paddr, OFS_OSCTRM): o_prdata <= {26'h0, osctrim_q};
          hit(i_paddr, OFS_REFCFG): o_prdata <= {26'h0, reftrim_q};
          default: o_prdata <= 32'h0;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registered outputs to the analog side and interrupts
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_sys_rst_hold <= 1'b0;
      o_main_warn_irq <= 1'b0;
      o_ref_warn_irq <= 1'b0;
      o_ht_irq <= 1'b0;
      o_warn_det_en <= 1'b0;
      o_prec_ref_en <= 1'b0;
      o_ref_reg_en <= 1'b0;
      o_temp_en <= 1'b0;
      o_osc_en <= 1'b1;
    end else begin
      o_sys_rst_hold <= low_rst_act;
      o_main_warn_irq <= wmain_q & wmain_ie_q;
      o_ref_warn_irq <= wref_q & wref_ie_q;
      o_ht_irq <= ht_flag_q & ht_ie_q;
      o_warn_det_en <= ~reduced;
      o_prec_ref_en <= ~reduced;
      o_ref_reg_en <= ~refdn_q;
      o_temp_en <= ten_q & ~reduced;
      o_osc_en <= ~reduced | oscstp_q;
    end
  end

  // Configuration fields passed straight out
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_ref_thr_sel <= RST_REFTHR;
      o_temp_sel <= 1'b0;
      o_ht_trim_en <= 1'b0;
      o_ht_trim <= RST_TTRIM;
      o_osc_trim <= RST_OSCTRIM;
      o_ref_trim <= RST_REFTRIM;
    end else begin
      o_ref_thr_sel <= refthr_q;
      o_temp_sel <= tsel_q;
      o_ht_trim_en <= trmen_q;
      o_ht_trim <= ttrim_q;
      o_osc_trim <= osctrim_q;
      o_ref_trim <= reftrim_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);

  a_rst_hold_set: assert property (low_rst_act |=> o_sys_rst_hold)
    else $error("reset hold missing");
  a_hold_off_reduced: assert property (reduced |=> !o_sys_rst_hold)
    else $error("reset hold in reduced mode");
  a_low_flag_set: assert property ($rose(low_rst_act) |=>
    low_rst_flag_q) else $error("low reset flag not set");
  a_pwr_on_kept: assert property (pwr_on_flag_q && !wr |=>
    pwr_on_flag_q) else $error("power-on flag lost");
  a_main_set_cause: assert property ($rose(wmain_q) |->
    $past(s[S_WMAIN]) && !$past(reduced))
    else $error("main warning set without cause");
  a_main_ack_clear: assert property (wr && hit(i_paddr, OFS_LVW1) &&
    wd[B_WACK] && !(s[S_WMAIN] && !reduced) |=> !wmain_q)
    else $error("main warning not cleared");
  a_ack_zero_keeps: assert property (wref_q && wr &&
    hit(i_paddr, OFS_LVW2) && !wd[B_WACK] |=> wref_q)
    else $error("reference warning lost on zero write");
  a_irq_level: assert property (
    wmain_q && wmain_ie_q |=> o_main_warn_irq)
    else $error("main interrupt missing");
  a_ht_change_flag: assert property (
    ht_ie_q && (s[S_HTCMP] != hts_q) |=> ht_flag_q ##1
    o_ht_irq || !ht_ie_q || !ht_flag_q)
    else $error("temperature change not flagged");
  a_trim_locked: assert property (wr && !gwe_q |=>
    $stable(osctrim_q) && $stable(ttrim_q) && $stable(reftrim_q))
    else $error("protected write took effect");
  a_temp_off_reduced: assert property (reduced |=> !o_temp_en)
    else $error("sensor on in reduced mode");
  a_osc_stop: assert property (reduced && !oscstp_q |=> !o_osc_en)
    else $error("oscillator not stopped");
  a_apb_ready: assert property (i_psel && !i_penable |=> o_pready ##1
    !o_pready) else $error("ready timing wrong");

  c_main_warn_irq: cover property (wmain_ie_q ##1 o_main_warn_irq);
  c_ht_toggle: cover property (ht_ie_q && $fell(hts_q));
  c_locked_write: cover property (wr && !gwe_q && hit(i_paddr, OFS_OSCTRM));
  c_rst_hold: cover property ($rose(o_sys_rst_hold));

endmodule
`default_nettype wire

// [dv/pmf_top_bench.sv]
// Self-checking bench for the power monitor flag logic
`timescale 1ns/100ps
`default_nettype none
module pmf_top_bench
  import pmf_pkg::*;
;
  // Compare one design value with its expected value
  `define CHK(a, b, m) begin checked++; if ((a) !== (b)) begin errors++; \
    $display("CHECK FAILED %0t %s", $time, m); end end
  logic i_mclk, i_rst_n, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [2:0] sup_low;
  logic mwarn, rwarn, prdy, srdy, htc, redm, sreq, err;
  logic hold, mirq, rirq, hirq, wden, pren, rren, ten, tsel, hten, osen;
  logic [1:0] thr;
  logic [3:0] httr;
  logic [5:0] rtr, otr;
  int errors = 0;
  int checked = 0;
  ////////////////////////////////////////////////////////////////////////////
  // Device under test, every pin connected
  pmf_top i_pmf_top (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_psel(psel),
    .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
    .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(pslverr), .i_supply_low(sup_low), .i_main_warn(mwarn),
    .i_ref_warn(rwarn), .i_prec_ref_rdy(prdy), .i_ref_sup_rdy(srdy),
    .i_ht_cmp(htc), .i_reduced_mode(redm), .i_sys_rst_req(sreq),
    .o_sys_rst_hold(hold), .o_main_warn_irq(mirq), .o_ref_warn_irq(rirq),
    .o_ht_irq(hirq), .o_ref_thr_sel(thr), .o_warn_det_en(wden),
    .o_prec_ref_en(pren), .o_ref_reg_en(rren), .o_ref_trim(rtr),
    .o_temp_en(ten), .o_temp_sel(tsel), .o_ht_trim_en(hten),
    .o_ht_trim(httr), .o_osc_en(osen), .o_osc_trim(otr));
  ////////////////////////////////////////////////////////////////////////////
  // Clock at 50 ns period
  initial begin
    i_mclk = 1'b0;
    forever #25 i_mclk = ~i_mclk;
  end
  // Print the verdict and stop
  task automatic results();
    if (errors == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // Cut a hang short
  initial begin
    repeat (4000) @(posedge i_mclk);
    errors++;
    results();
  end
  // Let a few edges pass so synchronised inputs reach the outputs
  task automatic wt(input int n);
    repeat (n) @(posedge i_mclk);
  endtask
  // One APB transfer; request held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge i_mclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge i_mclk);
    penable <= 1'b1;
    do begin @(posedge i_mclk); n++; end while (pready !== 1'b1 && n < 20);
    if (n >= 20) errors++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Reset flags and their preservation across other resets
  task automatic t_reset_flags();
    apb(1'b0, OFS_RST, 32'h0); `CHK(rd[1:0], 2'h3, "por flags")
    `CHK(otr, RST_OSCTRIM, "osc trim reset")
    apb(1'b1, OFS_RST, 32'h0); sreq <= 1'b1; wt(8); sreq <= 1'b0; wt(8);
    apb(1'b0, OFS_RST, 32'h0);
    `CHK(rd[1:0], 2'h3, "w0 and sysrst kept")
    apb(1'b1, OFS_RST, 32'h3); apb(1'b0, OFS_RST, 32'h0);
    `CHK(rd[1:0], 2'h0, "w1c clears flags")
    sup_low <= 3'h2; wt(8); `CHK(hold, 1'b1, "hold on low")
    apb(1'b0, OFS_RST, 32'h0); `CHK(rd[1:0], 2'h2, "low reset flag")
    sup_low <= 3'h0; wt(8); `CHK(hold, 1'b0, "hold released")
  endtask
  // Warning flag, gated interrupt and acknowledge for one supply
  task automatic t_warn(input logic [7:0] a, input logic m);
    if (m) mwarn <= 1'b1; else rwarn <= 1'b1;
    wt(8); apb(1'b0, a, 32'h0); `CHK(rd[0], 1'b1, "warn flag")
    `CHK(m ? mirq : rirq, 1'b0, "irq masked")
    apb(1'b1, a, 32'h2); wt(2); `CHK(m ? mirq : rirq, 1'b1, "irq")
    mwarn <= 1'b0; rwarn <= 1'b0; wt(8);
    apb(1'b0, a, 32'h0); `CHK(rd[0], 1'b1, "flag held")
    apb(1'b1, a, 32'h6); wt(2); apb(1'b0, a, 32'h0);
    `CHK(rd[0], 1'b0, "ack clears")
    `CHK(m ? mirq : rirq, 1'b0, "irq drops")
  endtask
  // Write protection of trims, threshold select, unmapped access
  task automatic t_protect();
    apb(1'b1, OFS_OSCTRM, 32'h15); apb(1'b1, OFS_TPTM, 32'h83); wt(2);
    `CHK(otr, RST_OSCTRIM, "osc trim locked")
    `CHK({hten, httr}, {1'b0, RST_TTRIM}, "temp trim locked")
    apb(1'b1, OFS_CTRL, 32'h5); apb(1'b1, OFS_OSCTRM, 32'h15);
    apb(1'b1, OFS_TPTM, 32'h85); apb(1'b1, OFS_REFCFG, 32'h11); wt(2);
    `CHK(otr, 6'h15, "osc trim")
    `CHK({hten, httr}, 5'h15, "temp trim")
    `CHK(rtr, 6'h11, "ref trim")
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, OFS_REFLVW, 32'(i)); wt(2);
      `CHK(thr, 2'(i), "thr select")
    end
    apb(1'b1, 8'h40, 32'h1); `CHK(err, 1'b1, "unmapped err")
  endtask
  // Sensor enable, output select and high temperature flag
  task automatic t_temp();
    apb(1'b1, OFS_TPCTRL, 32'h3); wt(2);
    `CHK({ten, tsel}, 2'h3, "bandgap out")
    apb(1'b1, OFS_TPCTRL, 32'h9); htc <= 1'b1; wt(8);
    `CHK({ten, tsel}, 2'h2, "sensor out")
    apb(1'b0, OFS_TPCTRL, 32'h0); `CHK(rd[4:2], 3'h7, "hot flag")
    `CHK(hirq, 1'b1, "ht irq")
    apb(1'b1, OFS_TPCTRL, 32'h19); wt(2); apb(1'b0, OFS_TPCTRL, 32'h0);
    `CHK(rd[4], 1'b0, "ht cleared")
    `CHK(hirq, 1'b0, "ht irq drops")
    htc <= 1'b0; wt(8); apb(1'b0, OFS_TPCTRL, 32'h0);
    `CHK(rd[4:2], 3'h6, "cool flag")
  endtask
  // Ready status and reduced performance mode
  task automatic t_reduced();
    prdy <= 1'b1; srdy <= 1'b1; wt(8); apb(1'b0, OFS_STAT, 32'h0);
    `CHK(rd[2:0], 3'h5, "ready flags")
    apb(1'b1, OFS_CTRL, 32'h7); wt(8); apb(1'b0, OFS_STAT, 32'h0);
    `CHK({rren, rd[0]}, 2'h0, "reg off")
    redm <= 1'b1; sup_low <= 3'h1; mwarn <= 1'b1; wt(8);
    `CHK({wden, pren, ten, hold}, 4'h0, "reduced off")
    `CHK(osen, 1'b1, "osc kept")
    apb(1'b0, OFS_LVW1, 32'h0); `CHK(rd[0], 1'b0, "no warn")
    apb(1'b0, OFS_STAT, 32'h0); `CHK(rd[2], 1'b0, "prec off")
    apb(1'b1, OFS_CTRL, 32'h1); wt(2); `CHK(osen, 1'b0, "osc stop")
    redm <= 1'b0; sup_low <= 3'h0; mwarn <= 1'b0; wt(8);
    `CHK({osen, wden}, 2'h3, "full mode")
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    i_rst_n = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 8'h00; pwdata = 32'h0; sup_low = 3'h0; mwarn = 1'b0;
    rwarn = 1'b0; prdy = 1'b0; srdy = 1'b0; htc = 1'b0; redm = 1'b0;
    sreq = 1'b0;
    wt(6); i_rst_n <= 1'b1; wt(8);
    t_reset_flags();
    t_warn(OFS_LVW1, 1'b1);
    t_warn(OFS_LVW2, 1'b0);
    t_protect();
    t_temp();
    t_reduced();
    i_rst_n <= 1'b0; wt(2); i_rst_n <= 1'b1; wt(8);
    apb(1'b0, OFS_RST, 32'h0); `CHK(rd[0], 1'b1, "por again")
    results();
  end
endmodule
`default_nettype wire
